// File: common/gpio_pkg.sv
// shared constants and types for the dual six-bit port block
package gpio_pkg;
    localparam int unsigned PORT_W          = 6;
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] PORT_A_LVL_OFF  = 12'h000;
    localparam logic [11:0] PORT_A_DIR_OFF  = 12'h004;
    localparam logic [11:0] PORT_C_LVL_OFF  = 12'h008;
    localparam logic [11:0] PORT_C_DIR_OFF  = 12'h00c;
    localparam logic [11:0] CFG_OFF         = 12'h010;
    localparam logic [11:0] CMP_MODE_OFF    = 12'h014;
    // direction resets to all inputs, latches to zero
    localparam logic [5:0]  DIR_RESET       = 6'h3f;
    localparam logic [5:0]  LAT_RESET       = 6'h00;
    // analog select: reset leaves all port C pins analog
    localparam logic [5:0]  ANALOG_RESET    = 6'h3f;
    localparam int unsigned DIR_A_FIXED_BIT = 3;
    localparam int unsigned OSC_PIN_LO      = 4;
    localparam int unsigned OSC_PIN_HI      = 5;
    localparam int unsigned CFG_OSC_LSB     = 0;
    localparam int unsigned CFG_OSC_W       = 3;
    localparam logic [2:0]  OSC_MODE_RESET  = 3'h0;

    typedef enum logic [2:0] {
        INTERNAL_OSC_MODE       = 3'h0,
        LOW_POWER_CRYSTAL_MODE  = 3'h1,
        CRYSTAL_OSC_MODE        = 3'h2,
        HIGH_SPEED_CRYSTAL_MODE = 3'h3
    } osc_mode_e;

    typedef struct packed {
        logic [5:0] out_val;
        logic [5:0] out_en_n;
    } pin_drive_s;
endpackage : gpio_pkg

// File: hw/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned W = 6
) (
    input  wire logic         CLK,
    input  wire logic         RESET_N,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = D;
        q_next    = meta_reg;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign Q = q_reg;
endmodule : pin_sync

// File: hw/dual_io_port.sv
// dual six-bit general purpose port with apb register access
// How it works
// R01: reading a level register returns the synchronised pin levels, bits 5..0.
// R02: direction bit one tri-states the pin, zero enables its driver.
// R03: bits 7 and 6 of level and direction registers ignore writes, read zero.
// R04: port a direction bit 3 always reads one; that pin is input only.
// R05: in any crystal oscillator mode port a direction bits 5..4 read one.
// R06: port c has six pins, each digital or comparator analog input.
// R07: a pin selected as analog reads zero in its level register.
// R08: software programs comparator mode before using a shared pin digitally.
// R09: writing a level register loads the output latch, driven where direction is zero.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module dual_io_port
    import gpio_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [5:0]  PORT_A_IN,
    output logic      [5:0]  PORT_A_OUT,
    output logic      [5:0]  PORT_A_OE_N,
    input  wire logic [5:0]  PORT_C_IN,
    output logic      [5:0]  PORT_C_OUT,
    output logic      [5:0]  PORT_C_OE_N,
    output logic      [5:0]  ANALOG_SELECT
);
    typedef enum logic [2:0] {
        REG_LVL_A,
        REG_DIR_A,
        REG_LVL_C,
        REG_DIR_C,
        REG_CFG,
        REG_CMP,
        REG_NONE
    } reg_sel_e;

    logic [5:0]  lat_a_reg;
    logic [5:0]  lat_a_next;
    logic [5:0]  lat_c_reg;
    logic [5:0]  lat_c_next;
    logic [5:0]  dir_a_reg;
    logic [5:0]  dir_a_next;
    logic [5:0]  dir_c_reg;
    logic [5:0]  dir_c_next;
    logic [2:0]  osc_reg;
    logic [2:0]  osc_next;
    logic [5:0]  analog_reg;
    logic [5:0]  analog_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [5:0]  pin_a;
    logic [5:0]  pin_c;
    logic [5:0]  level_c_view;
    logic [5:0]  dir_a_view;
    logic [5:0]  oe_n_a;
    logic [5:0]  oe_n_c;
    logic        crystal;
    logic        wr_en;
    logic        rd_en;
    logic        wr_lane;
    logic        mapped;
    reg_sel_e    reg_sel;
    pin_drive_s  drive_a;
    pin_drive_s  drive_c;

    // one decode of the word address, shared by the write, read and error paths
    function automatic reg_sel_e decode(input logic [11:0] addr);
        reg_sel_e sel;
        sel = REG_NONE;
        case (addr)
            PORT_A_LVL_OFF: begin
                sel = REG_LVL_A;
            end
            PORT_A_DIR_OFF: begin
                sel = REG_DIR_A;
            end
            PORT_C_LVL_OFF: begin
                sel = REG_LVL_C;
            end
            PORT_C_DIR_OFF: begin
                sel = REG_DIR_C;
            end
            CFG_OFF: begin
                sel = REG_CFG;
            end
            CMP_MODE_OFF: begin
                sel = REG_CMP;
            end
            default: begin
                sel = REG_NONE;
            end
        endcase
        return sel;
    endfunction : decode

    // the three crystal modes hand port a pins 5..4 to the oscillator
    function automatic logic is_crystal(input logic [2:0] mode);
        return (mode == LOW_POWER_CRYSTAL_MODE) ||
               (mode == CRYSTAL_OSC_MODE) ||
               (mode == HIGH_SPEED_CRYSTAL_MODE);
    endfunction : is_crystal

    // pins are asynchronous to CLK, so levels pass two flops first
    pin_sync #(.W(PORT_W)) sync_a (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .D       (PORT_A_IN),
        .Q       (pin_a)
    );

    pin_sync #(.W(PORT_W)) sync_c (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .D       (PORT_C_IN),
        .Q       (pin_c)
    );

    // writes land in the access cycle; reads are captured in the setup cycle
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PENABLE && !PWRITE;
    // only the low byte lane carries data bits, so a write without it changes nothing
    assign wr_lane = wr_en && PSTRB[0];
    assign reg_sel = decode(PADDR);
    assign mapped  = (reg_sel != REG_NONE);
    assign crystal = is_crystal(osc_reg);

    // output latches; they keep their value while the pin is an input
    always_comb begin
        lat_a_next = lat_a_reg;
        lat_c_next = lat_c_reg;
        if (wr_lane && reg_sel == REG_LVL_A) begin
            lat_a_next = PWDATA[5:0];                                // see R09, R03
        end
        if (wr_lane && reg_sel == REG_LVL_C) begin
            lat_c_next = PWDATA[5:0];                                // see R09, R03
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            lat_a_reg <= LAT_RESET;
            lat_c_reg <= LAT_RESET;
        end else begin
            lat_a_reg <= lat_a_next;
            lat_c_reg <= lat_c_next;
        end
    end

    // direction registers; port a bit 3 is stored as one so that pin never drives
    always_comb begin
        dir_a_next = dir_a_reg;
        dir_c_next = dir_c_reg;
        if (wr_lane && reg_sel == REG_DIR_A) begin
            dir_a_next                  = PWDATA[5:0];               // see R03
            dir_a_next[DIR_A_FIXED_BIT] = 1'b1;                      // see R04
        end
        if (wr_lane && reg_sel == REG_DIR_C) begin
            dir_c_next = PWDATA[5:0];                                // see R03
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            dir_a_reg <= DIR_RESET;
            dir_c_reg <= DIR_RESET;
        end else begin
            dir_a_reg <= dir_a_next;
            dir_c_reg <= dir_c_next;
        end
    end

    // oscillator mode and comparator analog select
    // analog select resets to all ones, so software clears it before any digital use
    always_comb begin
        osc_next    = osc_reg;
        analog_next = analog_reg;
        if (wr_lane && reg_sel == REG_CFG) begin
            osc_next = PWDATA[CFG_OSC_LSB +: CFG_OSC_W];
        end
        if (wr_lane && reg_sel == REG_CMP) begin
            analog_next = PWDATA[5:0];                               // see R06, R08
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            osc_reg    <= OSC_MODE_RESET;
            analog_reg <= ANALOG_RESET;
        end else begin
            osc_reg    <= osc_next;
            analog_reg <= analog_next;
        end
    end

    // read view of port a direction; the stored crystal-mode bits are kept
    always_comb begin
        dir_a_view                  = dir_a_reg;
        dir_a_view[DIR_A_FIXED_BIT] = 1'b1;                          // see R04
        if (crystal) begin
            dir_a_view[OSC_PIN_HI] = 1'b1;                           // see R05
            dir_a_view[OSC_PIN_LO] = 1'b1;                           // see R05
        end
    end

    // per-pin gating; oscillator and input-only pins follow the read view
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        assign level_c_view[i] = pin_c[i] & ~analog_reg[i];          // see R07
        assign oe_n_a[i]       = dir_a_view[i];                      // see R02, R04, R05
        // analog pins keep their driver off so the comparator sees the board
        assign oe_n_c[i]       = dir_c_reg[i] | analog_reg[i];       // see R02, R06
    end

    // read data captured in the setup cycle and shown in the access cycle
    // unmapped addresses read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_en) begin
            rdata_next = 32'h0000_0000;
            case (reg_sel)
                REG_LVL_A: begin
                    rdata_next[5:0] = pin_a;                         // see R01
                end
                REG_LVL_C: begin
                    rdata_next[5:0] = level_c_view;                  // see R01, R07
                end
                REG_DIR_A: begin
                    rdata_next[5:0] = dir_a_view;                    // see R03
                end
                REG_DIR_C: begin
                    rdata_next[5:0] = dir_c_reg;                     // see R03
                end
                REG_CFG: begin
                    rdata_next[CFG_OSC_LSB +: CFG_OSC_W] = osc_reg;
                end
                REG_CMP: begin
                    rdata_next[5:0] = analog_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // struct carriers for the pin drive
    always_comb begin
        drive_a.out_val  = lat_a_reg;                                // see R09
        drive_a.out_en_n = oe_n_a;                                   // see R02
        drive_c.out_val  = lat_c_reg;                                // see R09
        drive_c.out_en_n = oe_n_c;                                   // see R02
    end

    assign PORT_A_OUT    = drive_a.out_val;
    assign PORT_A_OE_N   = drive_a.out_en_n;
    assign PORT_C_OUT    = drive_c.out_val;
    assign PORT_C_OE_N   = drive_c.out_en_n;
    assign ANALOG_SELECT = analog_reg;
    assign PRDATA        = rdata_reg;
    assign PREADY        = 1'b1;
    assign PSLVERR       = PSEL && PENABLE && !mapped;
endmodule : dual_io_port

// File: tb/pin_board.sv
// board model of the circuitry on the port pins
`timescale 1ns/1ps
module pin_board
    import gpio_pkg::*;
(
    input  wire pin_drive_s drv,
    input  wire logic [5:0] ext,
    output logic      [5:0] pin
);
    // the board source only wins where the device has released the pin
    assign pin = (drv.out_val & ~drv.out_en_n) | (ext & drv.out_en_n);
endmodule : pin_board

// File: tb/dual_io_port_sva.sv
// assertions on the dual port block ports
`timescale 1ns/1ps
module dual_io_port_sva
    import gpio_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic [5:0]  PORT_A_OUT,
    input wire logic [5:0]  PORT_A_OE_N,
    input wire logic [5:0]  PORT_C_OUT,
    input wire logic [5:0]  PORT_C_OE_N,
    input wire logic [5:0]  ANALOG_SELECT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_wr(logic [11:0] a);
        PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    property p_lat_a; s_wr(PORT_A_LVL_OFF) |=> PORT_A_OUT == $past(PWDATA[5:0]); endproperty
    a_lat_a: assert property (p_lat_a) else $error("port a latch");
    property p_lat_c; s_wr(PORT_C_LVL_OFF) |=> PORT_C_OUT == $past(PWDATA[5:0]); endproperty
    a_lat_c: assert property (p_lat_c) else $error("port c latch");
    property p_dir_c; s_wr(PORT_C_DIR_OFF) |=> PORT_C_OE_N == ($past(PWDATA[5:0]) | ANALOG_SELECT); endproperty
    a_dir_c: assert property (p_dir_c) else $error("port c enable");
    property p_pin3; PORT_A_OE_N[3] == 1'b1; endproperty
    a_pin3: assert property (p_pin3) else $error("port a pin 3 driven");
    property p_hi; PSEL && PENABLE |-> PRDATA[31:6] == '0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_ana; s_rd(PORT_C_LVL_OFF) |=> (PRDATA[5:0] & $past(ANALOG_SELECT)) == '0; endproperty
    a_ana: assert property (p_ana) else $error("analog pin reads one");
    property p_ana_oe; (ANALOG_SELECT & ~PORT_C_OE_N) == '0; endproperty
    a_ana_oe: assert property (p_ana_oe) else $error("analog pin driven");
    property p_err; PSEL && PENABLE && PADDR > CMP_MODE_OFF |-> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");
endmodule : dual_io_port_sva
bind dual_io_port dual_io_port_sva dual_io_port_sva_inst (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PSTRB, .PRDATA, .PSLVERR, .PORT_A_OUT, .PORT_A_OE_N, .PORT_C_OUT, .PORT_C_OE_N, .ANALOG_SELECT);

// File: tb/six_bit_dual_io_port_bench.sv
// self-checking bench for the dual port block
`timescale 1ns/1ps
module six_bit_dual_io_port_bench;
    import gpio_pkg::*;
    logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [5:0]  ext_a = '0, ext_c = '0, pin_a, pin_c, ana;
    logic [3:0]  pstrb = 4'h1;
    pin_drive_s  drv_a, drv_c;
    int          error_cnt = 0, comparisons = 0;
    always #50 clk = ~clk;
    dual_io_port dual_io_port_inst (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PORT_A_IN(pin_a), .PORT_A_OUT(drv_a.out_val), .PORT_A_OE_N(drv_a.out_en_n),
        .PORT_C_IN(pin_c), .PORT_C_OUT(drv_c.out_val), .PORT_C_OE_N(drv_c.out_en_n), .ANALOG_SELECT(ana));
    pin_board board_a_inst (.drv(drv_a), .ext(ext_a), .pin(pin_a));
    pin_board board_c_inst (.drv(drv_c), .ext(ext_c), .pin(pin_c));
    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one idle edge first so release and the next setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // pins need two sync edges before a read can see them
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        repeat (3) @(posedge clk);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    task automatic t_port_a();
        chk(32'(drv_a.out_en_n), 32'h3f);
        chk(32'(drv_a.out_val), 32'h00);
        chk(32'(ana), 32'h3f);
        ext_a <= 6'h3f;
        apb(1'b1, PORT_A_DIR_OFF, 32'hff);
        rd_chk(PORT_A_DIR_OFF, 32'h3f);
        apb(1'b1, PORT_A_DIR_OFF, 32'hc0);
        rd_chk(PORT_A_DIR_OFF, 32'h08);
        chk(32'(drv_a.out_en_n), 32'h08);
        apb(1'b1, PORT_A_LVL_OFF, 32'hd5);
        rd_chk(PORT_A_LVL_OFF, 32'h1d);
        chk(32'(drv_a.out_val), 32'h15);
        chk(32'(er), 32'h0);
        // a write without the low byte lane must leave the latch alone
        pstrb <= 4'he;
        apb(1'b1, PORT_A_LVL_OFF, 32'h2a);
        pstrb <= 4'h1;
        rd_chk(PORT_A_LVL_OFF, 32'h1d);
    endtask : t_port_a
    task automatic t_osc();
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, CFG_OFF, 32'(m));
            rd_chk(PORT_A_DIR_OFF, (m inside {[1:3]}) ? 32'h38 : 32'h08);
            chk(32'(drv_a.out_en_n), (m inside {[1:3]}) ? 32'h38 : 32'h08);
        end
    endtask : t_osc
    task automatic t_port_c();
        ext_c <= 6'h3f;
        apb(1'b1, CMP_MODE_OFF, 32'h0);
        apb(1'b1, PORT_C_DIR_OFF, 32'hcc);
        rd_chk(PORT_C_DIR_OFF, 32'h0c);
        apb(1'b1, PORT_C_LVL_OFF, 32'h15);
        rd_chk(PORT_C_LVL_OFF, 32'h1d);
        chk(32'(drv_c.out_val), 32'h15);
        apb(1'b1, CMP_MODE_OFF, 32'h03);
        rd_chk(PORT_C_LVL_OFF, 32'h1c);
        chk(32'(ana), 32'h03);
        chk(32'(drv_c.out_en_n), 32'h0f);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
    endtask : t_port_c
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_port_a();
        t_osc();
        t_port_c();
        conclude();
    end
endmodule : six_bit_dual_io_port_bench
